/* File: hw/txr_defs.svh */
// Register offsets, field positions, reset values and limits of the
// transmit register group. Assumes a 9-bit byte address on the port.
`ifndef TXR_DEFS_SVH
`define TXR_DEFS_SVH

`define TXR_OFS_EVT_IEN   9'h1a0
`define TXR_OFS_HDLC_IEN  9'h1a1
`define TXR_OFS_SYNC_IEN  9'h1a2
`define TXR_OFS_CODE_A    9'h1ac
`define TXR_OFS_CODE_B    9'h1ad
`define TXR_OFS_FLAGS     9'h1b2
`define TXR_OFS_FREE      9'h1b3
`define TXR_OFS_FIFO      9'h1b4
`define TXR_OFS_MONITOR   9'h1bb
`define TXR_OFS_BLANK_A   9'h1c0
`define TXR_OFS_BLANK_B   9'h1c1
`define TXR_OFS_BLANK_C   9'h1c2
`define TXR_OFS_BLANK_D   9'h1c3

`define TXR_REG_RST       8'h00

`define TXR_HDLC_IEN_W    5
`define TXR_LINK_EMPTY    4
`define TXR_FLG_EMPTY     3
`define TXR_FLG_FULL      2
`define TXR_FLG_LWM       1
`define TXR_FLG_ROOM      0

`define TXR_FIFO_DEPTH    64
`define TXR_T1_CHANNELS   5'd24
`define TXR_LAST_BIT      3'h7

`endif

/* File: hw/txr_pkg.sv */
// Types shared by the transmit register group.
// Assumes txr_defs.svh carries every numeric constant.
package txr_pkg;

  typedef enum logic [3:0] {
    TXR_SEL_NONE,
    TXR_SEL_EVT_IEN,
    TXR_SEL_HDLC_IEN,
    TXR_SEL_SYNC_IEN,
    TXR_SEL_CODE_A,
    TXR_SEL_CODE_B,
    TXR_SEL_FLAGS,
    TXR_SEL_FREE,
    TXR_SEL_FIFO,
    TXR_SEL_MONITOR,
    TXR_SEL_BLANK_A,
    TXR_SEL_BLANK_B,
    TXR_SEL_BLANK_C,
    TXR_SEL_BLANK_D
  } txr_sel_t;

endpackage

/* File: hw/txr_fifo_mem.sv */
// Byte store of the transmit HDLC FIFO with a registered read word.
// Assumes one clock, synchronous strobes and a power-of-two depth.
`timescale 1ns/1ps
`default_nettype none
module txr_fifo_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 64
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       wr_valid_i,
  input  wire logic [W-1:0]               wr_data_i,
  output logic                            wr_ready_o,
  output logic                            rd_valid_o,
  output logic [W-1:0]                    rd_data_o,
  input  wire logic                       rd_ready_i,
  output logic [$clog2(DEPTH):0]          count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [CW-1:0]           cnt;
    logic                    out_v;
    logic [W-1:0]            out_d;
  } txr_mem_state_t;

  txr_mem_state_t cur;
  txr_mem_state_t next_st;
  logic           push;
  logic           load;

  always_comb begin
    next_st = cur;
    push    = wr_valid_i && (cur.cnt != CW'(DEPTH));
    load    = (cur.cnt != '0) && (!cur.out_v || rd_ready_i);
    if (push) begin
      next_st.mem[cur.wptr] = wr_data_i;
      next_st.wptr          = AW'(cur.wptr + 1'b1);
    end
    if (load) begin
      next_st.out_d = cur.mem[cur.rptr];
      next_st.out_v = 1'b1;
      next_st.rptr  = AW'(cur.rptr + 1'b1);
    end else if (rd_ready_i) begin
      next_st.out_v = 1'b0;
    end
    next_st.cnt = CW'(cur.cnt + CW'(push) - CW'(load));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else if (ce_i) begin
      cur <= next_st;
    end
  end

  assign wr_ready_o = cur.cnt != CW'(DEPTH);
  assign rd_valid_o = cur.out_v;
  assign rd_data_o  = cur.out_d;
  assign count_o    = cur.cnt;
endmodule
`default_nettype wire

/* File: hw/txr_skid.sv */
// Two-entry buffer between the FIFO store and the HDLC engine.
// Assumes one clock; a stall of the consumer loses no word.
`timescale 1ns/1ps
`default_nettype none
module txr_skid #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic         v0;
    logic         v1;
  } txr_skid_state_t;

  txr_skid_state_t cur;
  txr_skid_state_t next_st;

  always_comb begin
    next_st = cur;
    if (cur.v0 && out_ready_i) begin
      next_st.d0 = cur.d1;
      next_st.v0 = cur.v1;
      next_st.v1 = 1'b0;
    end
    if (in_valid_i && !cur.v1) begin
      if (!next_st.v0) begin
        next_st.d0 = in_data_i;
        next_st.v0 = 1'b1;
      end else begin
        next_st.d1 = in_data_i;
        next_st.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else if (ce_i) begin
      cur <= next_st;
    end
  end

  assign in_ready_o  = !cur.v1;
  assign out_valid_o = cur.v0;
  assign out_data_o  = cur.d0;
endmodule
`default_nettype wire

/* File: hw/txr_regs.sv */
// Transmit register group: interrupt enables, code pattern, HDLC FIFO,
// channel monitor and blank-channel selects behind the byte port.
// Assumes synchronous one-cycle RD and WR strobes and channel timing
// supplied by the framer as a bit strobe with channel and bit index.
`timescale 1ns/1ps
`default_nettype none
`include "txr_defs.svh"
module txr_regs #(
  parameter int FIFO_DEPTH = `TXR_FIFO_DEPTH
) (
  // Clock, reset and enable.
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       CE_I,
  // Microprocessor port.
  input  wire logic       CS_I,
  input  wire logic       RD_I,
  input  wire logic       WR_I,
  input  wire logic [8:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  output logic      [7:0] RDATA_O,
  // Mode and code length.
  input  wire logic       E1_MODE_I,
  input  wire logic [4:0] CODE_LEN_I,
  // Latched status flags kept outside and the interrupt pin.
  input  wire logic [7:0] EVT_LATCHED_I,
  input  wire logic [4:0] HDLC_LATCHED_I,
  input  wire logic       SYNC_LATCHED_I,
  output logic            INTERRUPT_OUT_N_O,
  // HDLC engine side of the FIFO.
  input  wire logic [6:0] LOW_WATERMARK_I,
  input  wire logic       TX_ACTIVE_I,
  input  wire logic       TX_EOM_MARKED_I,
  output logic      [7:0] HDLC_BYTE_O,
  output logic            HDLC_VALID_O,
  input  wire logic       HDLC_READY_I,
  output logic            TX_FIFO_UNDERRUN_O,
  output logic            TX_NOT_FULL_SET_O,
  output logic            TX_BELOW_WATERMARK_SET_O,
  // Serial data path and channel timing.
  input  wire logic       BIT_STROBE_I,
  input  wire logic [4:0] CHANNEL_I,
  input  wire logic [2:0] BIT_INDEX_I,
  input  wire logic [4:0] MONITOR_CHANNEL_I,
  input  wire logic       TX_SERIAL_INPUT_I,
  output logic            TX_SERIAL_O,
  output logic            CODE_BIT_O
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  generate
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64 ||
        (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two from 2 to 64");
    end
  endgenerate

  typedef struct packed {
    logic [7:0]  evt_ien;
    logic [4:0]  hdlc_ien;
    logic        sync_ien;
    logic [7:0]  code_a;
    logic [7:0]  code_b;
    logic [31:0] blank;
    logic [7:0]  rdata;
    logic [7:0]  mon;
    logic [6:0]  mon_sh;
    logic [3:0]  code_idx;
    logic        code_bit;
    logic        ser;
    logic        irq;
    logic        room_d;
    logic        lwm_d;
    logic        nf_set;
    logic        lwm_set;
    logic        underrun;
  } txr_regs_state_t;

  txr_regs_state_t  cur;
  txr_regs_state_t  next_st;
  txr_pkg::txr_sel_t sel;
  logic             wr_hit;
  logic             rd_hit;
  logic             fifo_wr;
  logic             fifo_wr_ready;
  logic             mem_valid;
  logic [7:0]       mem_data;
  logic             skid_ready;
  logic [CW-1:0]    fill;
  logic [6:0]       free_cnt;
  logic             is_empty;
  logic             is_full;
  logic             below_wm;
  logic             has_room;
  logic [15:0]      pattern;
  logic             blank_hit;
  logic             bit_tx;

  // Maps a port address onto the register it selects.
  function automatic txr_pkg::txr_sel_t txr_decode(input logic [8:0] a);
    txr_pkg::txr_sel_t s;
    s = txr_pkg::TXR_SEL_NONE;
    unique case (a)
      `TXR_OFS_EVT_IEN:  s = txr_pkg::TXR_SEL_EVT_IEN;
      `TXR_OFS_HDLC_IEN: s = txr_pkg::TXR_SEL_HDLC_IEN;
      `TXR_OFS_SYNC_IEN: s = txr_pkg::TXR_SEL_SYNC_IEN;
      `TXR_OFS_CODE_A:   s = txr_pkg::TXR_SEL_CODE_A;
      `TXR_OFS_CODE_B:   s = txr_pkg::TXR_SEL_CODE_B;
      `TXR_OFS_FLAGS:    s = txr_pkg::TXR_SEL_FLAGS;
      `TXR_OFS_FREE:     s = txr_pkg::TXR_SEL_FREE;
      `TXR_OFS_FIFO:     s = txr_pkg::TXR_SEL_FIFO;
      `TXR_OFS_MONITOR:  s = txr_pkg::TXR_SEL_MONITOR;
      `TXR_OFS_BLANK_A:  s = txr_pkg::TXR_SEL_BLANK_A;
      `TXR_OFS_BLANK_B:  s = txr_pkg::TXR_SEL_BLANK_B;
      `TXR_OFS_BLANK_C:  s = txr_pkg::TXR_SEL_BLANK_C;
      `TXR_OFS_BLANK_D:  s = txr_pkg::TXR_SEL_BLANK_D;
      default:           s = txr_pkg::TXR_SEL_NONE;
    endcase
    return s;
  endfunction

  assign sel     = txr_decode(ADDR_I);
  assign wr_hit  = CS_I && WR_I;
  assign rd_hit  = CS_I && RD_I;
  assign fifo_wr = wr_hit && (sel == txr_pkg::TXR_SEL_FIFO);

  // Bytes written while the store is full are dropped.
  txr_fifo_mem #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_mem (
    .clk_i      (CLK_I),
    .rst_i      (RESET_I),
    .ce_i       (CE_I),
    .wr_valid_i (fifo_wr),
    .wr_data_i  (WDATA_I),
    .wr_ready_o (fifo_wr_ready),
    .rd_valid_o (mem_valid),
    .rd_data_o  (mem_data),
    .rd_ready_i (skid_ready),
    .count_o    (fill)
  );

  txr_skid #(
    .W (8)
  ) u_skid (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .ce_i        (CE_I),
    .in_valid_i  (mem_valid),
    .in_data_i   (mem_data),
    .in_ready_o  (skid_ready),
    .out_valid_o (HDLC_VALID_O),
    .out_data_o  (HDLC_BYTE_O),
    .out_ready_i (HDLC_READY_I)
  );

  // Live FIFO condition, recomputed every cycle from the fill level.
  assign free_cnt = 7'(FIFO_DEPTH) - 7'(fill);
  assign is_empty = (fill == '0);
  assign is_full  = !fifo_wr_ready;
  assign below_wm = 7'(fill) < LOW_WATERMARK_I;
  assign has_room = fifo_wr_ready;

  // Unused code bits fall off the end because the index wraps early.
  assign pattern = {cur.code_a, cur.code_b};

  // Channels above the T1 frame have no blank bit outside E1.
  assign blank_hit = cur.blank[CHANNEL_I] &&
                     (E1_MODE_I || CHANNEL_I < `TXR_T1_CHANNELS);
  assign bit_tx    = blank_hit ? 1'b0 : TX_SERIAL_INPUT_I;

  always_comb begin
    next_st         = cur;
    next_st.nf_set  = 1'b0;
    next_st.lwm_set = 1'b0;

    if (wr_hit) begin
      unique case (sel)
        txr_pkg::TXR_SEL_EVT_IEN: begin
          next_st.evt_ien = WDATA_I;
        end
        txr_pkg::TXR_SEL_HDLC_IEN: begin
          next_st.hdlc_ien = WDATA_I[`TXR_HDLC_IEN_W-1:0];
        end
        txr_pkg::TXR_SEL_SYNC_IEN: begin
          next_st.sync_ien = WDATA_I[0];
        end
        txr_pkg::TXR_SEL_CODE_A: begin
          next_st.code_a = WDATA_I;
        end
        txr_pkg::TXR_SEL_CODE_B: begin
          next_st.code_b = WDATA_I;
        end
        txr_pkg::TXR_SEL_BLANK_A: begin
          next_st.blank[7:0] = WDATA_I;
        end
        txr_pkg::TXR_SEL_BLANK_B: begin
          next_st.blank[15:8] = WDATA_I;
        end
        txr_pkg::TXR_SEL_BLANK_C: begin
          next_st.blank[23:16] = WDATA_I;
        end
        txr_pkg::TXR_SEL_BLANK_D: begin
          next_st.blank[31:24] = WDATA_I;
        end
        default: begin
          next_st.blank = cur.blank;
        end
      endcase
    end

    // Reads only load the data register; no flag changes on a read.
    if (rd_hit) begin
      unique case (sel)
        txr_pkg::TXR_SEL_EVT_IEN: begin
          next_st.rdata = cur.evt_ien;
        end
        txr_pkg::TXR_SEL_HDLC_IEN: begin
          next_st.rdata = {3'h0, cur.hdlc_ien};
        end
        txr_pkg::TXR_SEL_SYNC_IEN: begin
          next_st.rdata = {7'h00, cur.sync_ien};
        end
        txr_pkg::TXR_SEL_CODE_A: begin
          next_st.rdata = cur.code_a;
        end
        txr_pkg::TXR_SEL_CODE_B: begin
          next_st.rdata = cur.code_b;
        end
        txr_pkg::TXR_SEL_FLAGS: begin
          next_st.rdata = `TXR_REG_RST;
          next_st.rdata[`TXR_FLG_EMPTY] = is_empty;
          next_st.rdata[`TXR_FLG_FULL]  = is_full;
          next_st.rdata[`TXR_FLG_LWM]   = below_wm;
          next_st.rdata[`TXR_FLG_ROOM]  = has_room;
        end
        txr_pkg::TXR_SEL_FREE: begin
          next_st.rdata = {1'b0, free_cnt};
        end
        txr_pkg::TXR_SEL_MONITOR: begin
          next_st.rdata = cur.mon;
        end
        txr_pkg::TXR_SEL_BLANK_A: begin
          next_st.rdata = cur.blank[7:0];
        end
        txr_pkg::TXR_SEL_BLANK_B: begin
          next_st.rdata = cur.blank[15:8];
        end
        txr_pkg::TXR_SEL_BLANK_C: begin
          next_st.rdata = cur.blank[23:16];
        end
        txr_pkg::TXR_SEL_BLANK_D: begin
          next_st.rdata = cur.blank[31:24];
        end
        default: begin
          next_st.rdata = `TXR_REG_RST;
        end
      endcase
    end

    if (BIT_STROBE_I) begin
      next_st.ser = bit_tx;
      if (CHANNEL_I == MONITOR_CHANNEL_I) begin
        if (BIT_INDEX_I == `TXR_LAST_BIT) begin
          next_st.mon = {cur.mon_sh, bit_tx};
        end else begin
          next_st.mon_sh = {cur.mon_sh[5:0], bit_tx};
        end
      end
      if (!E1_MODE_I) begin
        next_st.code_bit = pattern[4'hf - cur.code_idx];
        if (5'({1'b0, cur.code_idx} + 5'd1) >= CODE_LEN_I) begin
          next_st.code_idx = 4'h0;
        end else begin
          next_st.code_idx = 4'(cur.code_idx + 4'h1);
        end
      end else begin
        next_st.code_idx = 4'h0;
        next_st.code_bit = 1'b0;
      end
    end

    // Link-register-empty only interrupts in T1.
    next_st.irq = |(EVT_LATCHED_I & cur.evt_ien) |
                  |(HDLC_LATCHED_I & cur.hdlc_ien &
                    {!E1_MODE_I, 4'hf}) |
                  (SYNC_LATCHED_I & cur.sync_ien);

    next_st.room_d  = has_room;
    next_st.lwm_d   = below_wm;
    next_st.nf_set  = has_room && !cur.room_d;
    next_st.lwm_set = below_wm && !cur.lwm_d;

    // Engine wants a byte, none is ready and no end was marked.
    next_st.underrun = TX_ACTIVE_I && HDLC_READY_I && !HDLC_VALID_O &&
                       !TX_EOM_MARKED_I;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      // Edge detectors start at the idle level so reset shows no false edge.
      cur        <= '0;
      cur.room_d <= 1'b1;
      cur.lwm_d  <= 1'b1;
    end else if (CE_I) begin
      cur <= next_st;
    end
  end

  assign RDATA_O                  = cur.rdata;
  assign INTERRUPT_OUT_N_O        = !cur.irq;
  assign TX_FIFO_UNDERRUN_O       = cur.underrun;
  assign TX_NOT_FULL_SET_O        = cur.nf_set;
  assign TX_BELOW_WATERMARK_SET_O = cur.lwm_set;
  assign TX_SERIAL_O              = cur.ser;
  assign CODE_BIT_O               = cur.code_bit;
endmodule
`default_nettype wire

/* File: sim/txr_regs_checker.sv */
// Concurrent checks on the ports of the transmit register group.
// Assumes one clock, asynchronous reset and one-cycle port strobes.
`timescale 1ns/1ps
`default_nettype none
module txr_regs_checker (
  // Clock and reset.
  input wire logic       CLK_I,
  input wire logic       RESET_I,
  // Register port.
  input wire logic       CE_I,
  input wire logic       CS_I,
  input wire logic       RD_I,
  input wire logic       WR_I,
  input wire logic [8:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic [7:0] RDATA_O,
  // Flags and interrupt.
  input wire logic       E1_MODE_I,
  input wire logic [7:0] EVT_LATCHED_I,
  input wire logic [4:0] HDLC_LATCHED_I,
  input wire logic       SYNC_LATCHED_I,
  input wire logic       INTERRUPT_OUT_N_O,
  // FIFO drain.
  input wire logic       TX_ACTIVE_I,
  input wire logic       TX_EOM_MARKED_I,
  input wire logic [7:0] HDLC_BYTE_O,
  input wire logic       HDLC_VALID_O,
  input wire logic       HDLC_READY_I,
  input wire logic       TX_FIFO_UNDERRUN_O,
  input wire logic       TX_NOT_FULL_SET_O,
  // Serial path.
  input wire logic       BIT_STROBE_I,
  input wire logic [4:0] CHANNEL_I,
  input wire logic       TX_SERIAL_INPUT_I,
  input wire logic       TX_SERIAL_O
);
  logic [31:0] blank;
  logic        sync_en;
  logic        exp_ser;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  // Shadow copies of the blank selects and the sync interrupt enable.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      blank   <= 32'h0;
      sync_en <= 1'b0;
    end else if (CE_I && CS_I && WR_I) begin
      if (ADDR_I[8:2] == 7'h70) blank[ADDR_I[1:0]*8 +: 8] <= WDATA_I;
      if (ADDR_I == 9'h1a2) sync_en <= WDATA_I[0];
    end
  end

  // Channels 24 and above exist only in E1.
  assign exp_ser = TX_SERIAL_INPUT_I && !(blank[CHANNEL_I] && (E1_MODE_I || CHANNEL_I < 5'd24));

  sequence s_rd(a);
    CE_I && CS_I && RD_I && ADDR_I == a;
  endsequence
  sequence s_starved;
    CE_I && TX_ACTIVE_I && HDLC_READY_I && !HDLC_VALID_O && !TX_EOM_MARKED_I;
  endsequence

  property p_irq_clear;
    CE_I && EVT_LATCHED_I == 8'h00 && HDLC_LATCHED_I == 5'h00 && !SYNC_LATCHED_I
      |=> INTERRUPT_OUT_N_O;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt low with no flag");
  property p_irq_sync;
    CE_I && SYNC_LATCHED_I && sync_en |=> !INTERRUPT_OUT_N_O;
  endproperty
  a_irq_sync: assert property (p_irq_sync)
    else $error("enabled frame-loss flag gave no interrupt");
  property p_serial;
    CE_I && BIT_STROBE_I |=> TX_SERIAL_O == $past(exp_ser);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial output wrong for blank select");
  property p_underrun;
    s_starved |=> TX_FIFO_UNDERRUN_O;
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("starved transmitter gave no underrun");
  property p_free_msb;
    s_rd(9'h1b3) |=> !RDATA_O[7];
  endproperty
  a_free_msb: assert property (p_free_msb)
    else $error("free count bit 7 set");
  property p_flags_hi;
    s_rd(9'h1b2) |=> RDATA_O[7:4] == 4'h0 && !(RDATA_O[3] && RDATA_O[2]);
  endproperty
  a_flags_hi: assert property (p_flags_hi)
    else $error("flags show empty and full or unused bits");
  property p_full_room;
    s_rd(9'h1b2) |=> RDATA_O[2] != RDATA_O[0];
  endproperty
  a_full_room: assert property (p_full_room)
    else $error("full and room flags agree");
  property p_wo_read;
    s_rd(9'h1b4) |=> RDATA_O == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only place read non-zero");
  property p_hold;
    CE_I && HDLC_VALID_O && !HDLC_READY_I |=> HDLC_VALID_O && $stable(HDLC_BYTE_O);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled byte changed or vanished");
  property p_nf_pulse;
    CE_I && TX_NOT_FULL_SET_O |=> !TX_NOT_FULL_SET_O;
  endproperty
  a_nf_pulse: assert property (p_nf_pulse)
    else $error("not-full pulse stood two cycles");
endmodule
bind txr_regs txr_regs_checker u_txr_regs_checker (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .CS_I(CS_I), .RD_I(RD_I), .WR_I(WR_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .E1_MODE_I(E1_MODE_I),
  .EVT_LATCHED_I(EVT_LATCHED_I), .HDLC_LATCHED_I(HDLC_LATCHED_I),
  .SYNC_LATCHED_I(SYNC_LATCHED_I), .INTERRUPT_OUT_N_O(INTERRUPT_OUT_N_O),
  .TX_ACTIVE_I(TX_ACTIVE_I), .TX_EOM_MARKED_I(TX_EOM_MARKED_I), .HDLC_BYTE_O(HDLC_BYTE_O),
  .HDLC_VALID_O(HDLC_VALID_O), .HDLC_READY_I(HDLC_READY_I),
  .TX_FIFO_UNDERRUN_O(TX_FIFO_UNDERRUN_O), .TX_NOT_FULL_SET_O(TX_NOT_FULL_SET_O),
  .BIT_STROBE_I(BIT_STROBE_I), .CHANNEL_I(CHANNEL_I),
  .TX_SERIAL_INPUT_I(TX_SERIAL_INPUT_I), .TX_SERIAL_O(TX_SERIAL_O));
`default_nettype wire

/* File: sim/txr_regs_tb.sv */
// Self-checking bench for the transmit register group.
// Assumes the bound checker and a 16-byte FIFO to keep fills short.
`timescale 1ns/1ps
`default_nettype none
module txr_regs_tb;
  localparam int DEPTH = 16;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cs = 1'b0, rd = 1'b0, wr = 1'b0, e1 = 1'b0;
  logic sync_l = 1'b0, act = 1'b0, eom = 1'b0, hready = 1'b0, strobe = 1'b0, sin = 1'b0;
  logic irq_n, hvalid, undr, nfs, bws, sout, cbit;
  logic [8:0] addr = 9'h000, a;
  logic [7:0] wdata = 8'h00, evt = 8'h00, rdata, hbyte, r, v, pat_a, pat_b;
  logic [4:0] clen = 5'd8, hdlc_l = 5'h00, chan = 5'h00, mon = 5'h00, c5;
  logic [6:0] lwm = 7'd8;
  logic [2:0] bidx = 3'h0;
  logic [31:0] seed = 32'h4f8a4273, blank;
  int fails = 0, n_compared = 0, cycles = 0, n;
  int n_nfs = 0, n_bws = 0;
  logic [7:0] q[$];
  logic [8:0] ra [9] = '{9'h1a0, 9'h1a1, 9'h1a2, 9'h1ac, 9'h1ad, 9'h1c0, 9'h1c1, 9'h1c2, 9'h1c3};
  logic [7:0] rm [9] = '{8'hff, 8'h1f, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  int lens [6] = '{5, 6, 7, 8, 12, 16};

  txr_regs #(.FIFO_DEPTH(DEPTH)) u_txr_regs (
    .CLK_I(clk), .RESET_I(rst), .CE_I(ce), .CS_I(cs), .RD_I(rd), .WR_I(wr), .ADDR_I(addr),
    .WDATA_I(wdata), .RDATA_O(rdata), .E1_MODE_I(e1), .CODE_LEN_I(clen),
    .EVT_LATCHED_I(evt), .HDLC_LATCHED_I(hdlc_l), .SYNC_LATCHED_I(sync_l),
    .INTERRUPT_OUT_N_O(irq_n), .LOW_WATERMARK_I(lwm), .TX_ACTIVE_I(act),
    .TX_EOM_MARKED_I(eom), .HDLC_BYTE_O(hbyte), .HDLC_VALID_O(hvalid),
    .HDLC_READY_I(hready), .TX_FIFO_UNDERRUN_O(undr), .TX_NOT_FULL_SET_O(nfs),
    .TX_BELOW_WATERMARK_SET_O(bws), .BIT_STROBE_I(strobe), .CHANNEL_I(chan),
    .BIT_INDEX_I(bidx), .MONITOR_CHANNEL_I(mon), .TX_SERIAL_INPUT_I(sin),
    .TX_SERIAL_O(sout), .CODE_BIT_O(cbit));

  initial begin
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic f_code(input int i);
    logic [15:0] p;
    p = {pat_a, pat_b};
    return p[15-i];
  endfunction
  function automatic logic f_ser(input logic [4:0] c, input logic d, input logic m);
    return d && !(blank[c] && (m || c < 5'd24));
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wreg(input logic [8:0] ad, input logic [7:0] d);
    @(posedge clk);
    cs <= 1'b1;
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    cs <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [8:0] ad, output logic [7:0] d);
    @(posedge clk);
    cs <= 1'b1;
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    cs <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [8:0] ad, input logic [7:0] e, input string w);
    rreg(ad, r);
    chk(w, e, r);
  endtask
  task automatic strb(input logic [4:0] c, input logic [2:0] b, input logic d);
    @(posedge clk);
    strobe <= 1'b1;
    chan <= c;
    bidx <= b;
    sin <= d;
    @(posedge clk);
    strobe <= 1'b0;
    #1;
  endtask
  task automatic w2();
    repeat (2) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (nfs) n_nfs <= n_nfs + 1;
    if (bws) n_bws <= n_bws + 1;
    if (cycles == LIMIT) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rchk(ra[i], 8'h00, "reset value");
      v = 8'(rnd());
      wreg(ra[i], v);
      rchk(ra[i], v & rm[i], "read back");
    end
    rchk(9'h1b3, 8'(DEPTH), "free count");
    rchk(9'h1b2, 8'h0b, "live flags");
    rchk(9'h1bb, 8'h00, "monitor reset");
    wreg(9'h1a3, 8'hff);
    rchk(9'h1a3, 8'h00, "unmapped");
    rchk(9'h1b4, 8'h00, "write-only");
    wreg(9'h1b3, 8'hff);
    rchk(9'h1b3, 8'(DEPTH), "free after write");
    $display("registers test done");
    pat_a = 8'(rnd());
    pat_b = 8'(rnd());
    wreg(9'h1ac, pat_a);
    wreg(9'h1ad, pat_b);
    foreach (lens[j]) begin
      @(posedge clk);
      clen <= 5'(lens[j]);
      for (int k = 0; k < 2 * lens[j]; k++) begin
        strb(5'(k), 3'(k), 1'b0);
        chk("code bit", 8'(f_code(k % lens[j])), 8'(cbit));
      end
    end
    $display("code test done");
    for (int i = 0; i < 14; i++) begin
      a = (i < 8) ? 9'h1a0 : ((i < 13) ? 9'h1a1 : 9'h1a2);
      v = 8'(1 << ((i < 8) ? i : ((i < 13) ? i - 8 : 0)));
      wreg(a, v);
      @(posedge clk);
      evt <= (i < 8) ? v : 8'h00;
      hdlc_l <= (i >= 8 && i < 13) ? v[4:0] : 5'h00;
      sync_l <= (i == 13);
      w2();
      chk("irq enabled", 8'h00, 8'(irq_n));
      if (i == 12) begin
        @(posedge clk);
        e1 <= 1'b1;
        w2();
        chk("link empty in E1", 8'h01, 8'(irq_n));
        @(posedge clk);
        e1 <= 1'b0;
        w2();
      end
      wreg(a, 8'h00);
      w2();
      chk("irq masked", 8'h01, 8'(irq_n));
      @(posedge clk);
      evt <= 8'h00;
      hdlc_l <= 5'h00;
      sync_l <= 1'b0;
    end
    $display("interrupt test done");
    for (int i = 0; i < 4; i++) begin
      blank[i*8 +: 8] = 8'(rnd());
      wreg(9'h1c0 + 9'(i), blank[i*8 +: 8]);
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      e1 <= 1'(m);
      for (int c = 0; c < 32; c++) begin
        v = 8'(rnd());
        strb(5'(c), 3'h0, v[0]);
        chk("serial out", 8'(f_ser(5'(c), v[0], e1)), 8'(sout));
      end
    end
    for (int i = 0; i < 4; i++) begin
      wreg(9'h1c0 + 9'(i), 8'h00);
    end
    c5 = 5'(rnd());
    v = 8'(rnd());
    @(posedge clk);
    mon <= c5;
    for (int b = 0; b < 8; b++) begin
      strb(c5, 3'(b), v[7-b]);
    end
    rchk(9'h1bb, v, "monitor byte");
    $display("serial test done");
    n = 0;
    r = 8'h00;
    while (!r[2] && n < 40) begin
      v = 8'(rnd());
      q.push_back(v);
      wreg(9'h1b4, v);
      rreg(9'h1b2, r);
      n++;
    end
    chk("flags full", 8'h04, r);
    rchk(9'h1b3, 8'h00, "free at full");
    wreg(9'h1b4, 8'hee);
    rchk(9'h1b2, 8'h04, "flags reread");
    for (int t = 0; t < 400 && q.size() > 0; t++) begin
      @(posedge clk);
      if (hvalid && hready) chk("drained byte", q.pop_front(), hbyte);
      hready <= 1'(rnd());
    end
    chk("bytes left", 8'h00, 8'(q.size()));
    @(posedge clk);
    hready <= 1'b0;
    w2();
    w2();
    chk("dropped byte", 8'h00, 8'(hvalid));
    rchk(9'h1b2, 8'h0b, "flags empty");
    rchk(9'h1b3, 8'(DEPTH), "free empty");
    // One fill to full and one drain give one rising edge of each condition.
    chk("not-full pulses", 8'h01, 8'(n_nfs));
    chk("watermark pulses", 8'h01, 8'(n_bws));
    @(posedge clk);
    act <= 1'b1;
    hready <= 1'b1;
    w2();
    chk("underrun", 8'h01, 8'(undr));
    @(posedge clk);
    eom <= 1'b1;
    w2();
    chk("no underrun at end", 8'h00, 8'(undr));
    @(posedge clk);
    ce <= 1'b0;
    eom <= 1'b0;
    w2();
    chk("frozen by enable", 8'h00, 8'(undr));
    @(posedge clk);
    ce <= 1'b1;
    w2();
    chk("underrun after enable", 8'h01, 8'(undr));
    $display("fifo test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
